// >>> rtl/rbm_pkg.sv
// rbm_pkg: constants shared by the receive buffer manager files.
// assumes one 25 MHz clock; register offsets are local to the block.
package rbm_pkg;
  // register map, byte addresses on the 8-bit register port
  localparam logic [7:0] ADDR_FLAG  = 8'h00; // interrupt_flag_register
  localparam logic [7:0] ADDR_ENA   = 8'h01; // interrupt_enable_register
  localparam logic [7:0] ADDR_ERR   = 8'h02; // receive overflow flags
  localparam logic [7:0] ADDR_PIN   = 8'h03; // full_pin_control
  localparam logic [7:0] ADDR_CTRL0 = 8'h10; // rx_buffer_high_control
  localparam logic [7:0] ADDR_BUF0  = 8'h11; // first byte of high buffer
  localparam logic [7:0] ADDR_CTRL1 = 8'h20; // low buffer control
  localparam logic [7:0] ADDR_BUF1  = 8'h21; // first byte of low buffer
  // frame image: 4 id bytes, length byte, 8 data bytes
  localparam int          ASM_BYTES  = 13;
  // filter mode field encodings
  localparam logic [1:0] MODE_FILT  = 2'h0;
  localparam logic [1:0] MODE_STD   = 2'h1;
  localparam logic [1:0] MODE_EXT   = 2'h2;
  localparam logic [1:0] MODE_ANY   = 2'h3;
  // control register bit positions
  localparam int          CTL_MODE_LO = 5;
  localparam int          CTL_RTR     = 3;
  localparam int          CTL_ROLL    = 2;
  localparam int          CTL_ROLL_CP = 1;
  // full_pin_control bit positions (pin 0; pin 1 is one above)
  localparam int          PIN_EN      = 0;
  localparam int          PIN_MODE    = 2;
  localparam int          PIN_LEVEL   = 4;
  // values after reset
  localparam logic [7:0] RST_REG    = 8'h00;
  localparam logic        RST_PIN_N  = 1'b1;
  // filter numbering: buffer 0 owns filters 0..1, buffer 1 owns 2..5
  localparam logic [2:0] LOW_FILT_BASE = 3'h2;
  typedef enum logic {RBM_IDLE, RBM_BUSY} rbm_asm_t;
endpackage : rbm_pkg

// >>> rtl/rbm_accept.sv
// rbm_accept: acceptance decision for one receive buffer.
// assumes identifier matching under the mask is done outside and given
// as one match bit per filter, valid in the cycle a frame ends.
`timescale 1ns/1ns
module rbm_accept
  import rbm_pkg::*;
#(
  parameter int NF = 2,
  parameter int IW = 1
) (
  input  wire logic [1:0]    mode,
  input  wire logic [NF-1:0] match,
  input  wire logic [NF-1:0] fext,
  input  wire logic          frame_ext,
  input  wire logic          frame_err,
  output      logic          accept,
  output      logic [IW-1:0] hit_idx
);
  logic [NF-1:0] ok;

  // a filter counts only if its type select agrees with the frame and mode
  always_comb begin
    for (int i = 0; i < NF; i++) begin
      ok[i] = match[i] && (fext[i] == frame_ext)
              && !(mode == MODE_STD && fext[i])
              && !(mode == MODE_EXT && !fext[i]);
    end
  end

  // lowest matching filter wins; in the any mode the filters only report
  always_comb begin
    hit_idx = '0;
    for (int i = NF - 1; i >= 0; i--) begin
      if (ok[i]) begin
        hit_idx = IW'(i);
      end
    end
    if (mode == MODE_ANY) begin
      accept = 1'b1;
    end else begin
      accept = !frame_err && (|ok);
    end
  end
endmodule : rbm_accept

// >>> rtl/rbm_rx_manager.sv
// rbm_rx_manager: receive buffering behind a CAN protocol engine.
// assumes the engine delivers frame bytes in order, then one end or error
// pulse with type, remote flag and per-filter match bits; the register
// port is driven by a command decoder that supplies a bit-modify mask.
`timescale 1ns/1ns
module rbm_rx_manager
  import rbm_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // protocol engine side
  input  wire logic       fe_sof,
  input  wire logic       fe_byte_valid,
  input  wire logic [7:0] fe_byte,
  input  wire logic       fe_eof,
  input  wire logic       fe_err,
  input  wire logic       fe_ext,
  input  wire logic       fe_rtr,
  input  wire logic [5:0] filt_match,
  input  wire logic [5:0] filt_ext,
  // register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_wmask,
  output      logic [7:0] reg_rdata_ff,
  // pins
  output      logic       irq_n_ff,
  output      logic       buffer_full_pin0_n_ff,
  output      logic       buffer_full_pin1_n_ff
);
  rbm_asm_t   asm_state_ff;
  logic [3:0] asm_ptr_ff;
  logic [7:0] asm_mem_ff [0:ASM_BYTES-1];
  logic [7:0] buf_ff [0:1][0:ASM_BYTES-1];
  logic [1:0] receive_full_flag_ff;
  logic [1:0] receive_irq_enable_ff;
  logic [1:0] ovr_flag_ff;
  logic [5:0] full_pin_control_ff;
  logic [1:0] mode0_ff, mode1_ff;
  logic       rollover_enable_ff;
  logic       rtr0_ff, rtr1_ff;
  logic       filter_hit_bit_ff;
  logic [2:0] filhit1_ff;
  logic [0:0] idx0;
  logic [1:0] idx1;
  logic       acc0, acc1, commit, roll, want1;
  logic       load0, load1, ovr0, ovr1;
  logic [1:0] nxt_flag, nxt_ovr, nxt_ena;
  logic [5:0] nxt_pinctl;
  logic [7:0] ctrl0_val, ctrl1_val;
  logic [7:0] mod_pin, mod_ena, mod_c0, mod_c1;

  // masked write; a plain write comes with an all-ones mask
  function automatic logic [7:0] bit_modify(input logic [7:0] old_v,
                                            input logic [7:0] data,
                                            input logic [7:0] mask);
    return (old_v & ~mask) | (data & mask);
  endfunction : bit_modify

  // index into a buffer image, or ASM_BYTES when outside it
  function automatic logic [3:0] buf_index(input logic [7:0] addr,
                                           input logic [7:0] base);
    logic [7:0] d;
    d = addr - base;
    return (addr >= base && d < 8'(ASM_BYTES)) ? d[3:0] : 4'(ASM_BYTES);
  endfunction : buf_index

  // assembly stage: never stalled by the buffers, so no frame is missed
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      asm_state_ff <= RBM_IDLE;
      asm_ptr_ff   <= 4'h0;
    end else if (fe_sof) begin
      asm_state_ff <= RBM_BUSY;
      asm_ptr_ff   <= 4'h0;
    end else if (fe_eof || fe_err) begin
      asm_state_ff <= RBM_IDLE;
    end else if (fe_byte_valid && asm_ptr_ff < 4'(ASM_BYTES)) begin
      asm_ptr_ff   <= asm_ptr_ff + 4'h1;
    end
  end

  // frame bytes land at the running pointer; extra bytes are dropped
  always_ff @(posedge clk_sys) begin
    if (asm_state_ff == RBM_BUSY && !fe_sof && fe_byte_valid
        && asm_ptr_ff < 4'(ASM_BYTES)) begin
      asm_mem_ff[asm_ptr_ff] <= fe_byte;
    end
  end

  // acceptance per buffer; filters 0..1 serve buffer 0, 2..5 buffer 1
  rbm_accept #(.NF(2), .IW(1)) u_acc_high (
    .mode      (mode0_ff),
    .match     (filt_match[1:0]),
    .fext      (filt_ext[1:0]),
    .frame_ext (fe_ext),
    .frame_err (fe_err),
    .accept    (acc0),
    .hit_idx   (idx0)
  );
  rbm_accept #(.NF(4), .IW(2)) u_acc_low (
    .mode      (mode1_ff),
    .match     (filt_match[5:2]),
    .fext      (filt_ext[5:2]),
    .frame_ext (fe_ext),
    .frame_err (fe_err),
    .accept    (acc1),
    .hit_idx   (idx1)
  );

  // routing: a frame ends, picks a buffer, is loaded or counted as lost
  always_comb begin
    commit = asm_state_ff == RBM_BUSY && !fe_sof && (fe_eof || fe_err);
    roll   = commit && acc0 && receive_full_flag_ff[0]
             && rollover_enable_ff;
    want1  = roll || (commit && !acc0 && acc1);
    load0  = commit && acc0 && !receive_full_flag_ff[0];
    load1  = want1 && !receive_full_flag_ff[1];
    ovr0   = commit && acc0 && receive_full_flag_ff[0]
             && !rollover_enable_ff;
    ovr1   = want1 && receive_full_flag_ff[1];
  end

  // whole image copied, whatever the identifier type or length
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < ASM_BYTES; i++) begin
      if (load0) begin
        buf_ff[0][i] <= asm_mem_ff[i];
      end
      if (load1) begin
        buf_ff[1][i] <= asm_mem_ff[i];
      end
    end
  end

  // flags: a load in the clearing cycle wins, so no frame goes unseen;
  // the host can only clear flag bits, never set them
  always_comb begin
    nxt_flag = receive_full_flag_ff;
    nxt_ovr  = ovr_flag_ff;
    if (reg_wr && reg_addr == ADDR_FLAG) begin
      nxt_flag = receive_full_flag_ff & ~(reg_wmask[1:0] & ~reg_wdata[1:0]);
    end
    if (reg_wr && reg_addr == ADDR_ERR) begin
      nxt_ovr = ovr_flag_ff & ~(reg_wmask[1:0] & ~reg_wdata[1:0]);
    end
    nxt_flag = nxt_flag | {load1, load0};
    nxt_ovr  = nxt_ovr | {ovr1, ovr0};
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      receive_full_flag_ff <= 2'h0;
      ovr_flag_ff          <= 2'h0;
    end else begin
      receive_full_flag_ff <= nxt_flag;
      ovr_flag_ff          <= nxt_ovr;
    end
  end

  // enables and pin control; level bits take the bit-modify mask so one
  // pin can change without touching the other
  assign mod_pin = bit_modify(8'(full_pin_control_ff), reg_wdata, reg_wmask);
  assign mod_ena = bit_modify(8'(receive_irq_enable_ff), reg_wdata, reg_wmask);
  assign mod_c0  = bit_modify(ctrl0_val, reg_wdata, reg_wmask);
  assign mod_c1  = bit_modify(ctrl1_val, reg_wdata, reg_wmask);
  always_comb begin
    nxt_pinctl = full_pin_control_ff;
    nxt_ena    = receive_irq_enable_ff;
    if (reg_wr && reg_addr == ADDR_PIN) begin
      nxt_pinctl = mod_pin[5:0];
    end
    if (reg_wr && reg_addr == ADDR_ENA) begin
      nxt_ena = mod_ena[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      receive_irq_enable_ff <= 2'h0;
      full_pin_control_ff   <= 6'h00;
    end else begin
      full_pin_control_ff   <= nxt_pinctl;
      receive_irq_enable_ff <= nxt_ena;
    end
  end

  // control registers: mode and rollover written by host, rest by frames
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode0_ff           <= MODE_FILT;
      mode1_ff           <= MODE_FILT;
      rollover_enable_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_CTRL0) begin
        mode0_ff           <= mod_c0[CTL_MODE_LO +: 2];
        rollover_enable_ff <= mod_c0[CTL_ROLL];
      end
      if (reg_wr && reg_addr == ADDR_CTRL1) begin
        mode1_ff <= mod_c1[CTL_MODE_LO +: 2];
      end
    end
  end

  // status per load: which filter let the frame in, and remote request
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rtr0_ff           <= 1'b0;
      rtr1_ff           <= 1'b0;
      filter_hit_bit_ff <= 1'b0;
      filhit1_ff        <= 3'h0;
    end else begin
      if (load0) begin
        rtr0_ff           <= fe_rtr;
        filter_hit_bit_ff <= idx0[0];
      end
      if (load1) begin
        rtr1_ff    <= fe_rtr;
        // a rolled frame keeps the number of the high-buffer filter
        filhit1_ff <= roll ? {2'h0, idx0}
                           : LOW_FILT_BASE + {1'b0, idx1};
      end
    end
  end

  // control images; unimplemented bits 7 and 4 read zero
  always_comb begin
    ctrl0_val = {1'b0, mode0_ff, 1'b0, rtr0_ff, rollover_enable_ff,
                 rollover_enable_ff, filter_hit_bit_ff};
    ctrl1_val = {1'b0, mode1_ff, 1'b0, rtr1_ff, filhit1_ff};
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= RST_REG;
    end else if (reg_rd) begin
      if (buf_index(reg_addr, ADDR_BUF0) != 4'(ASM_BYTES)) begin
        reg_rdata_ff <= buf_ff[0][buf_index(reg_addr, ADDR_BUF0)];
      end else if (buf_index(reg_addr, ADDR_BUF1) != 4'(ASM_BYTES)) begin
        reg_rdata_ff <= buf_ff[1][buf_index(reg_addr, ADDR_BUF1)];
      end else begin
        unique case (reg_addr)
          ADDR_FLAG:  reg_rdata_ff <= {6'h00, receive_full_flag_ff};
          ADDR_ENA:   reg_rdata_ff <= {6'h00, receive_irq_enable_ff};
          ADDR_ERR:   reg_rdata_ff <= {6'h00, ovr_flag_ff};
          ADDR_PIN:   reg_rdata_ff <= {2'h0, full_pin_control_ff};
          ADDR_CTRL0: reg_rdata_ff <= ctrl0_val;
          ADDR_CTRL1: reg_rdata_ff <= ctrl1_val;
          default:    reg_rdata_ff <= RST_REG;
        endcase
      end
    end
  end

  // pins from next-state values so they move on the same edge as flags;
  // a disabled pin idles high
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_n_ff              <= RST_PIN_N;
      buffer_full_pin0_n_ff <= RST_PIN_N;
      buffer_full_pin1_n_ff <= RST_PIN_N;
    end else begin
      irq_n_ff <= !(|(nxt_flag & nxt_ena));
      buffer_full_pin0_n_ff <= !nxt_pinctl[PIN_EN] ? 1'b1
                    : nxt_pinctl[PIN_MODE] ? !nxt_flag[0]
                    : nxt_pinctl[PIN_LEVEL];
      buffer_full_pin1_n_ff <= !nxt_pinctl[PIN_EN+1] ? 1'b1
                    : nxt_pinctl[PIN_MODE+1] ? !nxt_flag[1]
                    : nxt_pinctl[PIN_LEVEL+1];
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_load_sets_flag;
    load0 |=> receive_full_flag_ff[0] && $past(asm_mem_ff[4]) == buf_ff[0][4];
  endproperty
  a_load_sets_flag: assert property (p_load_sets_flag)
    else $error("high buffer load did not set flag or copy image");

  property p_locked;
    receive_full_flag_ff[1] |=> $stable(buf_ff[1][0]) && $stable(rtr1_ff);
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked low buffer was overwritten");

  property p_irq;
    ##1 irq_n_ff == !(|(receive_full_flag_ff & receive_irq_enable_ff));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt pin disagrees with flags and enables");

  property p_roll;
    roll && !receive_full_flag_ff[1]
      |=> receive_full_flag_ff[1] && filhit1_ff == {2'h0, $past(idx0)}
          && ovr_flag_ff == $past(ovr_flag_ff);
  endproperty
  a_roll: assert property (p_roll)
    else $error("rollover did not land in low buffer cleanly");

  property p_overflow;
    commit && acc0 && receive_full_flag_ff[0] && !rollover_enable_ff
      |=> ovr_flag_ff[0] ##1 1'b1;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("dropped frame raised no overflow");

  property p_pin_irq_mode;
    ##1 (full_pin_control_ff[PIN_EN] && full_pin_control_ff[PIN_MODE])
      |-> buffer_full_pin0_n_ff == !receive_full_flag_ff[0];
  endproperty
  a_pin_irq_mode: assert property (p_pin_irq_mode)
    else $error("pin 0 does not follow its flag");

  property p_pin_gpo;
    ##1 (full_pin_control_ff[PIN_EN+1] && !full_pin_control_ff[PIN_MODE+1])
      |-> buffer_full_pin1_n_ff == full_pin_control_ff[PIN_LEVEL+1];
  endproperty
  a_pin_gpo: assert property (p_pin_gpo)
    else $error("pin 1 does not follow its level bit");

  property p_ctrl_zero;
    reg_rd && reg_addr == ADDR_CTRL0 |=> !reg_rdata_ff[7] && !reg_rdata_ff[4];
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero)
    else $error("unimplemented control bits read nonzero");

  property p_std_only;
    commit && fe_ext && mode0_ff == MODE_STD |-> !load0;
  endproperty
  a_std_only: assert property (p_std_only)
    else $error("extended frame loaded in standard-only mode");

  property p_rtr;
    load1 |=> rtr1_ff == $past(fe_rtr);
  endproperty
  a_rtr: assert property (p_rtr)
    else $error("remote flag not captured");

  c_load0: cover property (load0 ##[1:20] load1);
  c_roll:  cover property (roll && !receive_full_flag_ff[1]);
  c_ovr:   cover property (ovr0 || ovr1);
  c_gpo:   cover property (full_pin_control_ff[PIN_EN]
                           && !full_pin_control_ff[PIN_MODE]);
endmodule : rbm_rx_manager

// >>> verif/rbm_engine_model.sv
// rbm_engine_model: protocol engine that feeds frames to the manager.
// assumes the bench calls send_frame and drives filter configuration.
`timescale 1ns/1ns
module rbm_engine_model (
  input  wire logic       clk_sys,
  output      logic       fe_sof,
  output      logic       fe_byte_valid,
  output      logic [7:0] fe_byte,
  output      logic       fe_eof,
  output      logic       fe_err,
  output      logic       fe_ext,
  output      logic       fe_rtr,
  output      logic [5:0] filt_match
);
  // quiet link at time zero
  initial begin
    fe_sof        = 1'b0;
    fe_byte_valid = 1'b0;
    fe_byte       = 8'hA5;
    fe_eof        = 1'b0;
    fe_err        = 1'b0;
    fe_ext        = 1'b0;
    fe_rtr        = 1'b0;
    filt_match    = 6'h00;
  end

  // start, n bytes in order, then one end or error cycle with status;
  // status lines flip once stale so no old value is mistaken for data
  task automatic send_frame(input logic [103:0] img, input int n,
                            input logic ext, input logic rtr,
                            input logic err, input logic [5:0] m);
    @(posedge clk_sys);
    fe_sof <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      fe_sof        <= 1'b0;
      fe_byte_valid <= 1'b1;
      fe_byte       <= img[8*i +: 8];
    end
    @(posedge clk_sys);
    fe_sof        <= 1'b0;
    fe_byte_valid <= 1'b0;
    fe_byte       <= ~fe_byte;
    fe_eof        <= !err;
    fe_err        <= err;
    fe_ext        <= ext;
    fe_rtr        <= rtr;
    filt_match    <= m;
    @(posedge clk_sys);
    fe_eof     <= 1'b0;
    fe_err     <= 1'b0;
    fe_ext     <= !ext;
    fe_rtr     <= !rtr;
    filt_match <= ~m;
    @(posedge clk_sys);
  endtask : send_frame
endmodule : rbm_engine_model

// >>> verif/tb.sv
// tb: self-checking bench for the receive buffer manager.
// assumes the engine model drives the frame link; bench owns registers.
`timescale 1ns/1ns
module tb;
  import rbm_pkg::*;
  logic         clk_sys, rst_b, reg_wr, reg_rd;
  logic         fe_sof, fe_byte_valid, fe_eof, fe_err, fe_ext, fe_rtr;
  logic [7:0]   fe_byte, reg_addr, reg_wdata, reg_wmask, reg_rdata_ff, d;
  logic [5:0]   filt_match, filt_ext;
  logic         irq_n_ff, buffer_full_pin0_n_ff, buffer_full_pin1_n_ff;
  logic [103:0] img, img_old;
  logic [1:0]   md;
  logic         fx, fs, rtr, acc;
  logic [2:0]   f;
  int           n_fail, n_checks, seed;

  rbm_rx_manager rbm_rx_manager_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .fe_sof(fe_sof), .fe_byte_valid(fe_byte_valid), .fe_byte(fe_byte),
    .fe_eof(fe_eof), .fe_err(fe_err), .fe_ext(fe_ext), .fe_rtr(fe_rtr),
    .filt_match(filt_match), .filt_ext(filt_ext), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wmask(reg_wmask), .reg_rdata_ff(reg_rdata_ff),
    .irq_n_ff(irq_n_ff), .buffer_full_pin0_n_ff(buffer_full_pin0_n_ff),
    .buffer_full_pin1_n_ff(buffer_full_pin1_n_ff));
  rbm_engine_model rbm_engine_model_inst (.clk_sys(clk_sys),
    .fe_sof(fe_sof), .fe_byte_valid(fe_byte_valid), .fe_byte(fe_byte),
    .fe_eof(fe_eof), .fe_err(fe_err), .fe_ext(fe_ext), .fe_rtr(fe_rtr),
    .filt_match(filt_match));

  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held across exactly one sampling edge, then dropped
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [7:0] m);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wmask <= m;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_ff, exp);
  endtask : rd_chk

  // compare the first n bytes of a buffer against an image
  task automatic buf_chk(input logic [7:0] base, input logic [103:0] im,
                         input int n);
    for (int i = 0; i < n; i++) begin
      rd_chk(base + 8'(i), im[8*i +: 8]);
    end
  endtask : buf_chk

  task automatic settle();
    @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic new_img();
    for (int i = 0; i < 13; i++) begin
      img[8*i +: 8] = 8'($random(seed));
    end
  endtask : new_img

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  // acceptance expected for mode, frame type and filter type select
  function automatic logic exp_acc(input logic [1:0] m, input logic x,
                                   input logic s);
    if (m == MODE_ANY) return 1'b1;
    if (s != x) return 1'b0;
    return m == MODE_FILT || (m == MODE_STD && !x) || (m == MODE_EXT && x);
  endfunction : exp_acc

  // a hang would block the verdict, so cut it off well past the tests
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h0a38; n_fail = 0; n_checks = 0;
    rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 8'h00; reg_wmask = 8'hFF; filt_ext = 6'h00; img = '0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    chk({5'h00, irq_n_ff, buffer_full_pin0_n_ff, buffer_full_pin1_n_ff},
        8'h07);
    // buffer bytes hold no defined value before a load, so skip them
    foreach (d[i]) begin
      rd_chk(i < 4 ? 8'(i) : 8'(i % 4) << 4, RST_REG);
    end
    rd_chk(8'h7F, 8'h00);
    wr(ADDR_CTRL0, 8'hFF, 8'hFF);
    rd_chk(ADDR_CTRL0, 8'h66);
    wr(ADDR_CTRL0, 8'h00, 8'hFF);
    done("registers");
    // filter 1 of the high buffer, extended remote frame
    filt_ext <= 6'h02;
    new_img();
    rbm_engine_model_inst.send_frame(img, 13, 1'b1, 1'b1, 1'b0, 6'h02);
    rd_chk(ADDR_FLAG, 8'h01);
    rd_chk(ADDR_CTRL0, 8'h09);
    buf_chk(ADDR_BUF0, img, 13);
    rd_chk(ADDR_CTRL1, 8'h00);
    chk({7'h00, irq_n_ff}, 8'h01);
    wr(ADDR_ENA, 8'h03, 8'hFF);
    wr(ADDR_PIN, 8'h0F, 8'hFF);
    settle();
    chk({5'h00, irq_n_ff, buffer_full_pin0_n_ff, buffer_full_pin1_n_ff},
        8'h01);
    // locked buffer: frame dropped, overflow raised
    img_old = img;
    new_img();
    rbm_engine_model_inst.send_frame(img, 13, 1'b0, 1'b0, 1'b0, 6'h01);
    rd_chk(ADDR_ERR, 8'h01);
    buf_chk(ADDR_BUF0, img_old, 13);
    wr(ADDR_FLAG, 8'h00, 8'h01);
    wr(ADDR_ERR, 8'h00, 8'h01);
    settle();
    chk({6'h00, irq_n_ff, buffer_full_pin0_n_ff}, 8'h03);
    rbm_engine_model_inst.send_frame(img, 13, 1'b0, 1'b0, 1'b0, 6'h01);
    buf_chk(ADDR_BUF0, img, 13);
    rd_chk(ADDR_CTRL0, 8'h00);
    wr(ADDR_FLAG, 8'h00, 8'h01);
    done("high buffer");
    // every mode against both frame types on a random low filter
    for (int k = 0; k < 8; k++) begin
      md = 2'(k / 2);
      fx = 1'(k % 2);
      f = LOW_FILT_BASE + 3'($unsigned($random(seed)) % 4);
      fs = 1'($random(seed));
      rtr = 1'($random(seed));
      filt_ext <= 6'($random(seed)) & ~(6'h01 << f) | (6'(fs) << f);
      wr(ADDR_CTRL1, {1'b0, md, 5'h00}, 8'hFF);
      new_img();
      rbm_engine_model_inst.send_frame(img, 13, fx, rtr, 1'b0, 6'h01 << f);
      acc = exp_acc(md, fx, fs);
      rd_chk(ADDR_FLAG, {6'h00, acc, 1'b0});
      if (acc) buf_chk(ADDR_BUF1, img, 13);
      if (acc && md != MODE_ANY) begin
        rd_chk(ADDR_CTRL1, {1'b0, md, 1'b0, rtr, f});
      end
      if (acc) chk({7'h00, buffer_full_pin1_n_ff}, 8'h00);
      wr(ADDR_FLAG, 8'h00, 8'h02);
    end
    done("modes");
    // error frames: partial load in mode 11, dropped in mode 00
    new_img();
    rbm_engine_model_inst.send_frame(img, 5, 1'b0, 1'b0, 1'b1, 6'h04);
    rd_chk(ADDR_FLAG, 8'h02);
    buf_chk(ADDR_BUF1, img, 5);
    wr(ADDR_FLAG, 8'h00, 8'h02);
    wr(ADDR_CTRL1, 8'h00, 8'hFF);
    filt_ext <= 6'h00;
    rbm_engine_model_inst.send_frame(img, 7, 1'b0, 1'b0, 1'b1, 6'h04);
    rd_chk(ADDR_FLAG, 8'h00);
    done("error frames");
    // rollover from a full high buffer, low filters not matched
    wr(ADDR_CTRL0, 8'h04, 8'hFF);
    rbm_engine_model_inst.send_frame(img, 13, 1'b0, 1'b0, 1'b0, 6'h01);
    new_img();
    rbm_engine_model_inst.send_frame(img, 13, 1'b0, 1'b1, 1'b0, 6'h02);
    rd_chk(ADDR_FLAG, 8'h03);
    rd_chk(ADDR_ERR, 8'h00);
    rd_chk(ADDR_CTRL1, 8'h09);
    buf_chk(ADDR_BUF1, img, 13);
    wr(ADDR_FLAG, 8'h00, 8'h03);
    done("rollover");
    // standard-only high buffer refuses an extended frame
    wr(ADDR_CTRL0, 8'h20, 8'hFF);
    filt_ext <= 6'h03;
    rbm_engine_model_inst.send_frame(img, 13, 1'b1, 1'b0, 1'b0, 6'h03);
    rd_chk(ADDR_FLAG, 8'h00);
    rd_chk(ADDR_ERR, 8'h00);
    done("standard only");
    // output mode, levels changed by masked writes only
    wr(ADDR_PIN, 8'h03, 8'hFF);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_PIN, 8'(k) << PIN_LEVEL, 8'h30);
      settle();
      chk({6'h00, buffer_full_pin1_n_ff, buffer_full_pin0_n_ff}, 8'(k));
    end
    done("output pins");
    tally_and_finish();
  end
endmodule : tb
